/* logic/irq_prio_pkg.sv */
// Purpose: Shared constants for the two-level interrupt priority block
// Assumes: 8-bit register port, one core clock, six-state machine cycle
// Notes:   Offsets are word indices on the plain register port
package irq_prio_pkg;
    // ******************************************
    // Register port
    // ******************************************
    localparam int         ADDR_W          = 2;
    localparam int         DATA_W          = 8;
    localparam logic [1:0] OFS_LEVEL_SEL   = 2'h0;
    localparam logic [1:0] OFS_SRC_ENABLE  = 2'h1;
    localparam logic [1:0] OFS_STATUS      = 2'h2;
    localparam logic [7:0] LEVEL_SEL_RESET = 8'h00;
    localparam logic [7:0] SRC_EN_RESET    = 8'h00;

    // ******************************************
    // Field positions
    // ******************************************
    localparam int BIT_EXT0        = 0;  // ext0_level_bit / enable
    localparam int BIT_TIMER0      = 1;  // timer0_level_bit / enable
    localparam int BIT_EXT1        = 2;  // ext1_level_bit / enable
    localparam int BIT_TIMER1      = 3;  // timer1_level_bit / enable
    localparam int BIT_SERIAL      = 4;  // serial_level_bit / enable
    localparam int BIT_TIMER2      = 5;  // timer2_level_bit / enable
    localparam int BIT_RESERVED    = 6;
    localparam int BIT_BYPASS      = 7;  // priority_bypass_bit
    localparam int BIT_GLOBAL_EN   = 7;  // global_enable_bit
    localparam int BIT_STAT_HI_ACT = 7;
    localparam int BIT_STAT_LO_ACT = 6;
    localparam int MAX_SOURCES     = 6;
    localparam int SRC_W           = 3;

    // ******************************************
    // Machine cycle timing
    // ******************************************
    localparam int         STATES_PER_CYCLE = 6;
    localparam int         CLK_PER_STATE    = 2;
    localparam int         CLK_PER_CYCLE    = STATES_PER_CYCLE * CLK_PER_STATE;
    localparam int         CNT_W            = 4;
    localparam logic [3:0] SAMPLE_STATE     = 4'h5;  // Flags latched in state 5

    // ******************************************
    // Vector layout
    // ******************************************
    localparam logic [15:0] VECTOR_BASE_DEF = 16'h0003;
    localparam logic [15:0] VECTOR_STEP_DEF = 16'h0008;
endpackage

/* logic/machine_cycle_seq.sv */
// Purpose: Machine cycle state sequencer, six states of two clocks
// Assumes: clk is the oscillator rate
// Notes:   All outputs are registered or decoded from one counter
`timescale 1ns/1ps
`default_nettype none
module machine_cycle_seq
    import irq_prio_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Cycle timing
    output logic [3:0]            state_num,
    output logic                  phase2,
    output logic                  sample_end,
    output logic                  cycle_start
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;

    // Wrap the oscillator count at twelve periods
    always_comb begin
        next_st = st;
        if (st.cnt == CNT_W'(CLK_PER_CYCLE - 1)) begin
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Decodes of the running count
    assign state_num   = 4'(st.cnt >> 1) + 4'h1;
    assign phase2      = st.cnt[0];
    assign sample_end  = (state_num == SAMPLE_STATE) && phase2;
    assign cycle_start = (st.cnt == '0);
endmodule // machine_cycle_seq
`default_nettype wire

/* logic/irq_priority_ctrl.sv */
// Purpose: Two-level interrupt priority and vectoring for an 8-bit core
// Assumes: Source flags are generated and cleared outside this block
// Notes:   The core performs the long call; this block names the target
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module irq_priority_ctrl
    import irq_prio_pkg::*;
#(
    parameter int          NUM_SOURCES = 5,
    parameter logic [15:0] VECTOR_BASE = VECTOR_BASE_DEF,
    parameter logic [15:0] VECTOR_STEP = VECTOR_STEP_DEF
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [DATA_W-1:0]         reg_rdata,
    // Interrupt sources, bit order as the level select register
    input  wire logic [MAX_SOURCES-1:0] src_flags,
    // Core sequencer
    input  wire logic                 core_block,
    input  wire logic                 return_from_service_op,
    output logic                      long_call_op,
    output logic                      push_pc,
    output logic [15:0]               call_vector,
    output logic [SRC_W-1:0]          call_source,
    output logic                      service_hi_active,
    output logic                      service_lo_active,
    output logic [3:0]                cycle_state
);
    // ******************************************
    // State
    // ******************************************
    typedef struct packed {
        logic [7:0]             level_sel;
        logic [7:0]             src_en;
        logic [MAX_SOURCES-1:0] sample;
        logic                   sample_valid;
        logic                   hi_act;
        logic                   lo_act;
        logic                   call;
        logic [15:0]            vector;
        logic [SRC_W-1:0]       src;
        logic [DATA_W-1:0]      rdata;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;

    // Sources present in this variant
    localparam logic [MAX_SOURCES-1:0] SRC_MASK = MAX_SOURCES'((1 << NUM_SOURCES) - 1);

    logic                   phase2;
    logic                   sample_end;
    logic                   cycle_start;
    logic                   bypass;
    logic [MAX_SOURCES-1:0] eligible;
    logic [MAX_SOURCES-1:0] level_hi;
    logic [MAX_SOURCES-1:0] hi_cand;
    logic [MAX_SOURCES-1:0] lo_cand;
    logic [MAX_SOURCES-1:0] win_set;
    logic                   fire;
    logic                   win_high;
    logic [SRC_W-1:0]       win_src;

    // ******************************************
    // Machine cycle sequencer
    // ******************************************
    machine_cycle_seq u_seq (
        .clk         (clk),
        .rst_n       (rst_n),
        .state_num   (cycle_state),
        .phase2      (phase2),
        .sample_end  (sample_end),
        .cycle_start (cycle_start)
    );

    // ******************************************
    // Arbitration
    // ******************************************
    // With the bypass bit set every source is treated as low level, so
    // only the enables decide and nesting never occurs.
    assign bypass   = st.level_sel[BIT_BYPASS];
    assign level_hi = bypass ? '0 : (st.level_sel[MAX_SOURCES-1:0] & SRC_MASK);
    assign eligible = st.sample & st.src_en[MAX_SOURCES-1:0] & SRC_MASK
                      & {MAX_SOURCES{st.src_en[BIT_GLOBAL_EN]}};
    assign hi_cand  = eligible & level_hi;
    assign lo_cand  = eligible & ~level_hi;

    // High level only blocked by a running high service; low level by either
    always_comb begin
        win_high = 1'b0;
        win_set  = '0;
        if (!st.hi_act && (hi_cand != '0)) begin
            win_high = 1'b1;
            win_set  = hi_cand;
        end else if (!st.hi_act && !st.lo_act) begin
            win_set  = lo_cand;
        end
    end

    // Lowest bit index wins inside a level
    always_comb begin
        win_src = '0;
        for (int i = MAX_SOURCES - 1; i >= 0; i--) begin
            if (win_set[i]) begin
                win_src = SRC_W'(i);
            end
        end
    end

    // Polled at the first clock of the cycle after the sample
    assign fire = cycle_start && st.sample_valid && !core_block && (win_set != '0);

    // ******************************************
    // Next state
    // ******************************************
    always_comb begin
        next_st      = st;
        next_st.call = 1'b0;

        // Software writes to the level select and enable registers
        if (reg_wr) begin
            case (reg_addr)
                OFS_LEVEL_SEL:  next_st.level_sel = reg_wdata;
                OFS_SRC_ENABLE: next_st.src_en    = reg_wdata;
                default:        next_st.level_sel = st.level_sel;
            endcase
        end

        // Registered read data; reserved and absent bits read zero
        if (reg_rd) begin
            case (reg_addr)
                OFS_LEVEL_SEL: begin
                    next_st.rdata               = st.level_sel;
                    next_st.rdata[BIT_RESERVED] = 1'b0;
                    next_st.rdata[MAX_SOURCES-1:0] = st.level_sel[MAX_SOURCES-1:0] & SRC_MASK;
                end
                OFS_SRC_ENABLE: begin
                    next_st.rdata               = st.src_en;
                    next_st.rdata[BIT_RESERVED] = 1'b0;
                    next_st.rdata[MAX_SOURCES-1:0] = st.src_en[MAX_SOURCES-1:0] & SRC_MASK;
                end
                OFS_STATUS: begin
                    next_st.rdata                  = '0;
                    next_st.rdata[BIT_STAT_HI_ACT] = st.hi_act;
                    next_st.rdata[BIT_STAT_LO_ACT] = st.lo_act;
                    next_st.rdata[MAX_SOURCES-1:0] = st.sample;
                end
                default: next_st.rdata = '0;
            endcase
        end

        // Flags captured at the end of state 5
        if (sample_end) begin
            next_st.sample       = src_flags & SRC_MASK;
            next_st.sample_valid = 1'b1;
        end

        // Return clears the highest running level first
        if (return_from_service_op) begin
            if (st.hi_act) begin
                next_st.hi_act = 1'b0;
            end else begin
                next_st.lo_act = 1'b0;
            end
        end

        // Vectoring: a new service outranks a same-cycle return
        if (fire) begin
            next_st.call   = 1'b1;
            next_st.src    = win_src;
            next_st.vector = VECTOR_BASE + 16'(VECTOR_STEP * win_src);
            if (win_high) begin
                next_st.hi_act = 1'b1;
            end else begin
                next_st.lo_act = 1'b1;
            end
        end
    end

    // Single register stage for all state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st           <= '0;
            st.level_sel <= LEVEL_SEL_RESET;
            st.src_en    <= SRC_EN_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ******************************************
    // Outputs
    // ******************************************
    // Only the program counter is pushed; status and registers are left to software
    assign long_call_op      = st.call;
    assign push_pc           = st.call;
    assign call_vector       = st.vector;
    assign call_source       = st.src;
    assign service_hi_active = st.hi_act;
    assign service_lo_active = st.lo_act;
    assign reg_rdata         = st.rdata;

    // ******************************************
    // Assertions
    // ******************************************
    hi_blocks_all_a: assert property (@(posedge clk) disable iff (!rst_n) fire |-> !st.hi_act)
        else $error("service started during high level service");
    lo_preempt_a: assert property (@(posedge clk) disable iff (!rst_n) fire && st.lo_act |-> win_high)
        else $error("low request preempted low service");
    level_order_a: assert property (@(posedge clk) disable iff (!rst_n) fire && (hi_cand != '0) |-> win_high)
        else $error("low request won over high request");
    poll_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        fire |-> ((win_set & MAX_SOURCES'((1 << win_src) - 1)) == '0) && win_set[win_src])
        else $error("polling order violated");
    sample_hold_a: assert property (@(posedge clk) disable iff (!rst_n) !sample_end |=> $stable(st.sample))
        else $error("samples changed outside state 5");
    call_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
        long_call_op |-> $past(cycle_start) && cycle_state == 4'h1)
        else $error("long call not at the poll point");
    global_gate_a: assert property (@(posedge clk) disable iff (!rst_n) fire |-> st.src_en[BIT_GLOBAL_EN])
        else $error("interrupt taken with global enable low");
    return_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        return_from_service_op && st.hi_act |=> !service_hi_active)
        else $error("return did not clear high level flag");
    // The winner's level is judged in the poll cycle; one cycle later the new flag already blocks it
    level_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        fire |=> ($past(win_high) ? st.hi_act : st.lo_act) && long_call_op)
        else $error("in-progress flag not set on vectoring");
    cycle_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        cycle_start |-> ##12 cycle_start)
        else $error("machine cycle not twelve clocks");
    bypass_flat_a: assert property (@(posedge clk) disable iff (!rst_n) fire && bypass |-> !win_high)
        else $error("priority applied while bypassed");
    vector_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        long_call_op |-> call_vector == VECTOR_BASE + 16'(VECTOR_STEP * call_source))
        else $error("wrong vector address");

    // ******************************************
    // Further checks
    // ******************************************
    // Only the program counter is pushed, exactly with each call
    push_pair_a: assert property (@(posedge clk) disable iff (!rst_n) push_pc == long_call_op)
        else $error("push request differs from long call");
    // Sources beyond this variant never reach the core
    absent_src_a: assert property (@(posedge clk) disable iff (!rst_n)
        long_call_op |-> int'(call_source) < NUM_SOURCES)
        else $error("call to a source absent from this variant");
    // The winner's level follows its own bit unless bypassed
    level_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        fire && !bypass |-> win_high == st.level_sel[win_src])
        else $error("winner level does not match its level bit");
    // The winner must be flagged in the sample and enabled
    enable_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        fire |-> st.src_en[win_src] && st.sample[win_src])
        else $error("call to a disabled or idle source");
    // A core block at the poll point suppresses the call
    core_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        cycle_start && core_block |=> !long_call_op)
        else $error("call issued although the core blocked it");
    // A low winner needs both levels idle
    lo_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        fire && !win_high |-> !st.lo_act && !st.hi_act)
        else $error("low call while a service was running");
    // At most one call per machine cycle
    call_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
        long_call_op |=> (!long_call_op)[*8] ##1 (!long_call_op)[*3])
        else $error("two calls within one machine cycle");
    // Sampling happens in state 5 only
    sample_state_a: assert property (@(posedge clk) disable iff (!rst_n)
        sample_end |-> cycle_state == SAMPLE_STATE)
        else $error("flags sampled outside state 5");
    // Reset leaves every source at low level; checked one edge later to stay clear of the start-up race
    reset_level_a: assert property (@(posedge clk)
        !rst_n |=> st.level_sel == LEVEL_SEL_RESET && st.src_en == SRC_EN_RESET)
        else $error("registers not at reset value");
    // With no high service, a return ends the low service
    return_lo_a: assert property (@(posedge clk) disable iff (!rst_n)
        return_from_service_op && !st.hi_act && !fire |=> !service_lo_active)
        else $error("return did not clear low level flag");
    // Bypass never nests a second service
    bypass_nest_a: assert property (@(posedge clk) disable iff (!rst_n)
        bypass && st.lo_act |-> !fire)
        else $error("nested call while bypassed");
    // An eligible high request at an open poll is always taken
    high_take_a: assert property (@(posedge clk) disable iff (!rst_n)
        cycle_start && st.sample_valid && !core_block && !st.hi_act && (hi_cand != '0) |-> fire && win_high)
        else $error("eligible high request not taken");
    // A call always leaves an in-progress flag behind
    call_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        long_call_op |-> service_hi_active || service_lo_active)
        else $error("call without an in-progress flag");
    // Reserved bit reads zero outside the status word
    reserved_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(reg_rd) && $past(reg_addr) != OFS_STATUS |-> !reg_rdata[BIT_RESERVED])
        else $error("reserved level bit read as one");
    // The vector holds between calls
    vector_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !long_call_op |-> $stable(call_vector))
        else $error("vector changed without a call");
    // External input 0 wins whenever it is in the winning set
    first_poll_a: assert property (@(posedge clk) disable iff (!rst_n)
        fire && win_set[0] |-> win_src == '0)
        else $error("external input 0 not first in poll");
    // The high flag is only raised by vectoring
    hi_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(service_hi_active) |-> $past(fire))
        else $error("high flag set without a call");

    // Scenarios the bench must reach
    high_preempts_c: cover property (@(posedge clk) disable iff (!rst_n) fire && st.lo_act && win_high);
    bypass_fire_c:   cover property (@(posedge clk) disable iff (!rst_n) fire && bypass);
    tie_low_c:       cover property (@(posedge clk) disable iff (!rst_n) fire && !win_high && $countones(lo_cand) > 1);
    nested_return_c: cover property (@(posedge clk) disable iff (!rst_n)
                                     return_from_service_op && st.hi_act && st.lo_act);
    core_block_c:    cover property (@(posedge clk) disable iff (!rst_n) cycle_start && core_block && win_set != '0);
endmodule // irq_priority_ctrl
`default_nettype wire

/* testbench/core_seq_model.sv */
// Purpose: Behavioural core sequencer facing the interrupt priority block
// Assumes: One clock; the bench asks for each return from service
// Notes:   Keeps a call depth so that returns never outnumber calls
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // From the priority block
    input  wire logic       long_call_op,
    input  wire logic       push_pc,
    // Bench control
    input  wire logic       ret_req,
    // To the priority block and bench
    output logic            return_from_service_op,
    output logic [3:0]      depth,
    output logic            push_err
);
    // Return only from a routine that was entered; a stray return would hide a missing call
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            return_from_service_op <= 1'b0;
            depth                  <= 4'h0;
            push_err               <= 1'b0;
        end else begin
            return_from_service_op <= ret_req && (depth != 4'h0);
            depth                  <= depth + 4'(long_call_op) - 4'(return_from_service_op);
            push_err               <= push_err | (push_pc !== long_call_op);
        end
    end
endmodule // core_seq_model
`default_nettype wire

/* testbench/two_level_interrupt_priority_bench.sv */
// Purpose: Self-checking bench for the two-level interrupt priority block
// Assumes: Six-source variant, default vector layout
// Notes:   Every wait is bounded; a stuck wait counts as a mismatch
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_priority_bench
    import irq_prio_pkg::*;
;
    localparam int NS = 6;
    logic                   clk, rst_n, reg_wr, reg_rd, core_block, ret_req;
    logic [ADDR_W-1:0]      reg_addr;
    logic [DATA_W-1:0]      reg_wdata, reg_rdata, d;
    logic [MAX_SOURCES-1:0] src_flags, lvl, req;
    logic                   long_call_op, push_pc, return_from_service_op;
    logic                   service_hi_active, service_lo_active, push_err;
    logic [15:0]            call_vector;
    logic [SRC_W-1:0]       call_source;
    logic [3:0]             cycle_state, depth;
    int                     n_fail, cmp_count;

    irq_priority_ctrl #(.NUM_SOURCES(NS)) irq_priority_ctrl_i (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_flags(src_flags), .core_block(core_block),
        .return_from_service_op(return_from_service_op), .long_call_op(long_call_op),
        .push_pc(push_pc), .call_vector(call_vector), .call_source(call_source),
        .service_hi_active(service_hi_active), .service_lo_active(service_lo_active),
        .cycle_state(cycle_state));
    core_seq_model core_seq_model_i (
        .clk(clk), .rst_n(rst_n), .long_call_op(long_call_op), .push_pc(push_pc), .ret_req(ret_req),
        .return_from_service_op(return_from_service_op), .depth(depth), .push_err(push_err));

    // ******************************************
    // Clock, verdict, compare and bus tasks
    // ******************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Trailing edge keeps two strobes from being assigned in one time step
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] got;
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
        chk(got, exp);
        @(posedge clk);
    endtask
    task automatic do_ret();
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        @(posedge clk);
    endtask
    // ******************************************
    // Expectation helpers
    // ******************************************
    function automatic logic [2:0] lowest(input logic [5:0] v);
        lowest = 3'h0;
        for (int i = 5; i >= 0; i--) if (v[i]) lowest = 3'(i);
    endfunction
    task automatic expect_call(input logic [2:0] s, input logic hi);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (long_call_op !== 1'b1 && k < 40);
        if (k >= 40) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            end_of_test();
        end
        chk(cycle_state, 4'h1);
        chk(push_pc, 1'b1);
        chk(call_source, s);
        chk(call_vector, VECTOR_BASE_DEF + VECTOR_STEP_DEF * s);
        chk(hi ? service_hi_active : service_lo_active, 1'b1);
        @(posedge clk);
    endtask
    task automatic expect_none(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 chk(long_call_op, 1'b0);
        end
        @(posedge clk);
    endtask

    // ******************************************
    // Main sequence
    // ******************************************
    initial begin
        n_fail = 0; cmp_count = 0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 2'h0;
        reg_wdata = 8'h00; src_flags = 6'h00; core_block = 1'b0; ret_req = 1'b0;
        void'($urandom(32'h1d619152));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(OFS_LEVEL_SEL, LEVEL_SEL_RESET);
        rd(OFS_SRC_ENABLE, SRC_EN_RESET);
        d = 8'($urandom);
        wr(OFS_LEVEL_SEL, d);
        rd(OFS_LEVEL_SEL, d & 8'hbf);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        wr(OFS_SRC_ENABLE, 8'hbf);
        // Random levels and simultaneous requests
        for (int i = 0; i < 12; i++) begin
            lvl = 6'($urandom);
            req = 6'($urandom % 63 + 1);
            wr(OFS_LEVEL_SEL, {2'b00, lvl});
            src_flags <= req;
            if ((req & lvl) != 6'h00) expect_call(lowest(req & lvl), 1'b1);
            else expect_call(lowest(req), 1'b0);
            src_flags <= 6'h00;
            do_ret();
            @(posedge clk);
            #1 chk({service_hi_active, service_lo_active}, 2'b00);
            @(posedge clk);
        end
        // Nesting: low may yield to high only, high yields to nothing
        wr(OFS_LEVEL_SEL, 8'h0c);
        src_flags <= 6'h01;
        expect_call(3'h0, 1'b0);
        src_flags <= 6'h02;
        expect_none(30);
        src_flags <= 6'h06;
        expect_call(3'h2, 1'b1);
        rd(OFS_STATUS, 8'hc6);
        src_flags <= 6'h0a;
        expect_none(30);
        do_ret();
        expect_call(3'h3, 1'b1);
        src_flags <= 6'h00;
        do_ret();
        do_ret();
        @(posedge clk);
        #1 chk({service_hi_active, service_lo_active}, 2'b00);
        @(posedge clk);
        // Bypass treats every source as low level
        wr(OFS_LEVEL_SEL, 8'h84);
        src_flags <= 6'h05;
        expect_call(3'h0, 1'b0);
        src_flags <= 6'h04;
        expect_none(30);
        src_flags <= 6'h00;
        do_ret();
        // Global and per-source enables, then a core block
        wr(OFS_LEVEL_SEL, 8'h00);
        wr(OFS_SRC_ENABLE, 8'h3f);
        src_flags <= 6'h01;
        expect_none(30);
        wr(OFS_SRC_ENABLE, 8'hbe);
        expect_none(30);
        src_flags <= 6'h03;
        expect_call(3'h1, 1'b0);
        src_flags <= 6'h00;
        do_ret();
        core_block <= 1'b1;
        src_flags <= 6'h20;
        expect_none(30);
        core_block <= 1'b0;
        expect_call(3'h5, 1'b0);
        src_flags <= 6'h00;
        do_ret();
        #1 chk(depth, 4'h0);
        chk(push_err, 1'b0);
        end_of_test();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_of_test();
    end
endmodule // two_level_interrupt_priority_bench
`default_nettype wire
